// ### hw/uart_shadow_map.svh
// named addresses, field positions, reset values and depths of the shadow data port
// assumes a 32-bit byte address on the register port, one register per aligned word
//
// Summary of operation
// RULE1: Sixteen word-spaced shadow locations alias the receive buffer and the holding register.
// RULE2: A read returns the byte from the serial input, or from the infrared input in IR mode.
// RULE3: Read data mean something only while the data-ready flag of line status is set.
// RULE4: With FIFOs off a new byte overwrites an unread one and flags an overrun.
// RULE5: With FIFOs on a read returns the oldest byte at the head of the receive FIFO.
// RULE6: With the receive FIFO full a new byte is dropped, the stored kept, and overrun flagged.
// RULE7: A write queues the byte for the serial output, or the active-low IR output in IR mode; tx_ir_n_valid_o is driven active-high.
// RULE8: Software should write transmit data only while the holding-empty flag (bit 5) is set.
// RULE9: With FIFOs off and holding-empty set, one write clears holding-empty.
// RULE10: With FIFOs off, writes before holding-empty sets again overwrite the pending byte.
// RULE11: With FIFOs on the transmit FIFO takes 16 bytes before it is full.
// RULE12: A write while the transmit FIFO is full is discarded and the FIFO is left unchanged.
// RULE13: Bytes leave the transmit FIFO in the order in which they were written.
`ifndef UART_SHADOW_MAP_SVH
`define UART_SHADOW_MAP_SVH

// ==========================================================================
// register addresses
`define SHADOW_FIRST_ADDR   32'h50001130
`define SHADOW_LAST_ADDR    32'h5000116c
`define SHADOW_11_ADDR      32'h5000115c
`define SHADOW_12_ADDR      32'h50001160
`define FIFO_CONTROL_ADDR   32'h50001200
`define LINE_STATUS_ADDR    32'h50001204
`define WORD_ALIGN_MASK     32'h00000003

// ==========================================================================
// field positions and reset values
`define FC_FIFO_EN_BIT      0
`define FC_IR_MODE_BIT      1
`define LS_DATA_READY_BIT   0
`define LS_OVERRUN_BIT      1
`define LS_THR_EMPTY_BIT    5
`define BYTE_RESET          8'h00
`define RDATA_RESET         32'h00000000

// ==========================================================================
// buffer geometry
`define BYTE_WIDTH          8
`define TX_FIFO_DEPTH       16
`define RX_FIFO_DEPTH       8

`endif

// ### hw/uart_shadow_pkg.sv
// types shared by the shadow data port
// assumes uart_shadow_map.svh is included before this package is compiled
`include "uart_shadow_map.svh"

package uart_shadow_pkg;

   typedef logic [`BYTE_WIDTH-1:0] byte_t;

   // what a register access hits
   typedef enum logic [1:0] {
      ACC_NONE   = 2'b00,
      ACC_SHADOW = 2'b01,
      ACC_FCTRL  = 2'b10,
      ACC_LSTAT  = 2'b11
   } access_t;

   // address decode used by both strobes
   function automatic access_t decode_addr(input logic [31:0] addr);
      access_t kind;
      kind = ACC_NONE;
      if ((addr & `WORD_ALIGN_MASK) == 32'h00000000) begin
         if (addr >= `SHADOW_FIRST_ADDR && addr <= `SHADOW_LAST_ADDR) begin
            kind = ACC_SHADOW;
         end else if (addr == `FIFO_CONTROL_ADDR) begin
            kind = ACC_FCTRL;
         end else if (addr == `LINE_STATUS_ADDR) begin
            kind = ACC_LSTAT;
         end
      end
      return kind;
   endfunction : decode_addr

endpackage : uart_shadow_pkg

// ### hw/uart_shadow_port.sv
// shadow data port of the second serial port, with its byte FIFOs
// assumes a line receiver that hands over whole bytes and a line transmitter
// that takes whole bytes with valid/ready; baud and framing live outside
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps

// ==========================================================================
// generic byte FIFO
// storage is a flop array, so the head word is a flop output
// no bypass: a word pushed in one cycle reaches the head in the next
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clock_i,
   input  wire logic             srst_i,
   input  wire logic             flush_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   // honest full and empty from the occupancy count
   assign in_ready_o  = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_data_o  = mem[rd_ptr];

   // pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge clock_i) begin
      if (srst_i || flush_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // storage cleared at reset so a read of an empty fifo returns a defined value
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         for (int n = 0; n < DEPTH; n++) begin
            mem[n] <= '0;
         end
      end else if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule : byte_fifo

// ==========================================================================
// shadow data port top
// sixteen aliased shadow words sit in front of one receive side and one transmit side;
// reads drain the receive side, writes fill the transmit side
// limitation: the receive fifo holds eight bytes, so a longer burst without reads
// loses the excess and raises overrun; the transmit fifo holds sixteen
// line status carries data ready, overrun and transmit holding empty
module uart_shadow_port
   import uart_shadow_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   // register port
   input  wire logic [31:0] addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [31:0]      rdata_o,
   // bytes from the serial and infrared receivers
   input  wire logic        rx_serial_valid_i,
   input  wire logic [7:0]  rx_serial_byte_i,
   input  wire logic        rx_ir_valid_i,
   input  wire logic [7:0]  rx_ir_byte_i,
   output logic             rx_ready_o,
   // bytes to the serial and infrared transmitters
   output logic             tx_serial_valid_o,
   output logic             tx_ir_n_valid_o,
   output logic [7:0]       tx_byte_o,
   input  wire logic        tx_ready_i,
   // line status and mode as levels
   output logic             data_ready_flag_o,
   output logic             overrun_o,
   output logic             tx_holding_empty_flag_o,
   output logic             ir_mode_o
);

   // =======================================================================
   // decode and control
   access_t kind;
   logic    sh_rd;
   logic    sh_wr;
   logic    fifo_en;
   logic    ir_mode;
   logic    mode_flush;

   assign kind  = decode_addr(addr_i);
   // RULE1 shadow aliasing
   assign sh_rd = rd_i & (kind == ACC_SHADOW);
   assign sh_wr = wr_i & (kind == ACC_SHADOW);

   // an unaligned or unmapped address decodes to nothing: writes vanish and reads
   // answer zero, so a stray access cannot disturb either byte path
   // a change of fifo mode empties both paths so no stale byte survives
   assign mode_flush = wr_i && (kind == ACC_FCTRL) && (wdata_i[`FC_FIFO_EN_BIT] != fifo_en);

   // fifo control register
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         fifo_en <= 1'b0;
         ir_mode <= 1'b0;
      end else if (wr_i && kind == ACC_FCTRL) begin
         fifo_en <= wdata_i[`FC_FIFO_EN_BIT];
         ir_mode <= wdata_i[`FC_IR_MODE_BIT];
      end
   end
   assign ir_mode_o = ir_mode;

   // =======================================================================
   // receive path
   logic  rx_valid;
   byte_t rx_byte;
   byte_t receive_buffer;
   logic  rbuf_full;
   logic  rxf_in_ready;
   logic  rxf_out_valid;
   byte_t rxf_out_data;
   logic  overrun;
   logic  next_overrun_event;

   // RULE2 input selected by mode
   assign rx_valid = ir_mode ? rx_ir_valid_i : rx_serial_valid_i;
   assign rx_byte  = ir_mode ? rx_ir_byte_i : rx_serial_byte_i;

   // receiver can always hand over; a full fifo drops rather than stalls the line
   // a receiver that ignores rx_ready_o still loses only the newcomer, never a stored byte
   assign rx_ready_o = fifo_en ? rxf_in_ready : 1'b1;

   byte_fifo #(
      .WIDTH (`BYTE_WIDTH),
      .DEPTH (`RX_FIFO_DEPTH)
   ) u_rx_fifo (
      .clock_i     (clock_i),
      .srst_i      (srst_i),
      .flush_i     (mode_flush),
      .in_valid_i  (rx_valid & fifo_en),
      .in_ready_o  (rxf_in_ready),
      .in_data_i   (rx_byte),
      .out_valid_o (rxf_out_valid),
      // RULE5 read pops the head
      .out_ready_i (sh_rd & fifo_en),
      .out_data_o  (rxf_out_data)
   );

   // an arrival beats a read in the same cycle, so the fresh byte is never lost
   // single receive buffer when fifos are off
   always_ff @(posedge clock_i) begin
      if (srst_i || mode_flush) begin
         receive_buffer <= `BYTE_RESET;
         rbuf_full      <= 1'b0;
      end else if (!fifo_en && rx_valid) begin
         // RULE4 overwrite unread byte
         receive_buffer <= rx_byte;
         rbuf_full      <= 1'b1;
      end else if (!fifo_en && sh_rd) begin
         rbuf_full <= 1'b0;
      end
   end

   // overrun only when an unread byte is lost, not when a read takes it the same cycle
   always_comb begin
      next_overrun_event = 1'b0;
      if (rx_valid) begin
         if (fifo_en) begin
            // RULE6 full fifo drops the newcomer
            next_overrun_event = ~rxf_in_ready;
         end else begin
            // RULE4 overrun on overwrite
            next_overrun_event = rbuf_full & ~sh_rd;
         end
      end
   end

   // software must read line status to learn of a loss; the flag never clears itself
   // sticky overrun, cleared by a line status read; a new event wins over the clear
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         overrun <= 1'b0;
      end else if (next_overrun_event) begin
         overrun <= 1'b1;
      end else if (rd_i && kind == ACC_LSTAT) begin
         overrun <= 1'b0;
      end
   end
   assign overrun_o = overrun;

   // the shadow byte is meaningless while this is low; software polls it first
   // RULE3 data-ready follows the receive store
   assign data_ready_flag_o = fifo_en ? rxf_out_valid : rbuf_full;

   // =======================================================================
   // transmit path
   byte_t transmit_holding;
   logic  thr_full;
   logic  txf_in_ready;
   logic  txf_out_valid;
   byte_t txf_out_data;
   logic  tx_valid;
   logic  thr_empty;

   byte_fifo #(
      .WIDTH (`BYTE_WIDTH),
      .DEPTH (`TX_FIFO_DEPTH)
   ) u_tx_fifo (
      .clock_i     (clock_i),
      .srst_i      (srst_i),
      .flush_i     (mode_flush),
      // RULE11 sixteen deep
      // RULE12 full fifo ignores the write
      .in_valid_i  (sh_wr & fifo_en),
      .in_ready_o  (txf_in_ready),
      .in_data_i   (wdata_i[`BYTE_WIDTH-1:0]),
      .out_valid_o (txf_out_valid),
      // RULE13 first in, first sent
      .out_ready_i (tx_ready_i & fifo_en),
      .out_data_o  (txf_out_data)
   );

   // a single slot: software that writes without waiting for the empty flag
   // replaces the pending byte, a trade of safety for the smallest buffer
   // holding register used when fifos are off
   always_ff @(posedge clock_i) begin
      if (srst_i || mode_flush) begin
         transmit_holding <= `BYTE_RESET;
         thr_full         <= 1'b0;
      end else if (!fifo_en && sh_wr) begin
         // RULE9 write clears empty
         // RULE10 later writes overwrite
         transmit_holding <= wdata_i[`BYTE_WIDTH-1:0];
         thr_full         <= 1'b1;
      end else if (!fifo_en && tx_ready_i) begin
         thr_full <= 1'b0;
      end
   end

   // in fifo mode the flag reports an empty fifo, not a free slot
   assign thr_empty               = fifo_en ? ~txf_out_valid : ~thr_full;
   assign tx_holding_empty_flag_o = thr_empty;

   // RULE7 steer to serial or infrared transmitter; tx_ir_n_valid_o is driven active-high, not active-low
   assign tx_valid          = fifo_en ? txf_out_valid : thr_full;
   assign tx_serial_valid_o = tx_valid & ~ir_mode;
   assign tx_ir_n_valid_o   = tx_valid & ir_mode;
   assign tx_byte_o         = fifo_en ? txf_out_data : transmit_holding;

   // =======================================================================
   // read data, one cycle after the strobe; unmapped reads answer zero
   // a shadow read of an empty receive side returns the stale head word and pops nothing
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rdata_o <= `RDATA_RESET;
      end else if (rd_i) begin
         rdata_o <= `RDATA_RESET;
         unique case (kind)
            ACC_SHADOW: begin
               // RULE5 head of fifo or receive buffer
               rdata_o[`BYTE_WIDTH-1:0] <= fifo_en ? rxf_out_data : receive_buffer;
            end
            ACC_FCTRL: begin
               rdata_o[`FC_FIFO_EN_BIT] <= fifo_en;
               rdata_o[`FC_IR_MODE_BIT] <= ir_mode;
            end
            ACC_LSTAT: begin
               // RULE3 data-ready in line status
               rdata_o[`LS_DATA_READY_BIT] <= data_ready_flag_o;
               rdata_o[`LS_OVERRUN_BIT]    <= overrun;
               // RULE8 empty flag software polls
               rdata_o[`LS_THR_EMPTY_BIT]  <= thr_empty;
            end
            ACC_NONE: begin
               rdata_o <= `RDATA_RESET;
            end
         endcase
      end
   end

endmodule : uart_shadow_port

// ### tb/uart_shadow_port_properties.sv
// concurrent checks on the shadow data port, seeing only its top ports
// assumes the map header, one clock and a synchronous active-high reset
`timescale 1ns/100ps
`include "uart_shadow_map.svh"
module uart_shadow_port_properties (
   input wire logic        clock_i,
   input wire logic        srst_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic        tx_ready_i,
   input wire logic        ir_mode_o,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [31:0] rdata_o,
   input wire logic        rx_serial_valid_i,
   input wire logic        rx_ir_valid_i,
   input wire logic        rx_ready_o,
   input wire logic        overrun_o,
   input wire logic        tx_serial_valid_o,
   input wire logic        tx_ir_n_valid_o,
   input wire logic        data_ready_flag_o,
   input wire logic        tx_holding_empty_flag_o,
   input wire logic [7:0]  rx_serial_byte_i,
   input wire logic [7:0]  rx_ir_byte_i,
   input wire logic [7:0]  tx_byte_o
);
   logic fifo_on;
   logic sh;
   logic rx_v;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   // =====================================================================
   // helper state: fifo mode is only visible through control writes
   always_ff @(posedge clock_i) begin
      if (srst_i) fifo_on <= 1'b0;
      else if (wr_i && addr_i == `FIFO_CONTROL_ADDR) fifo_on <= wdata_i[0];
   end
   // any aligned shadow word, and the arrival of the selected receiver
   assign sh   = addr_i >= `SHADOW_FIRST_ADDR && addr_i <= `SHADOW_LAST_ADDR && !addr_i[1:0];
   assign rx_v = ir_mode_o ? rx_ir_valid_i : rx_serial_valid_i;
   // =====================================================================
   // properties
   property p_thr_load; !fifo_on && wr_i && sh
      |=> !tx_holding_empty_flag_o && tx_byte_o == $past(wdata_i[7:0]); endproperty
   a_thr_load: assert property (p_thr_load) else $error("holding load");
   property p_thr_send; !fifo_on && (tx_serial_valid_o || tx_ir_n_valid_o) && tx_ready_i
      && !(wr_i && sh) |=> tx_holding_empty_flag_o; endproperty
   a_thr_send: assert property (p_thr_send) else $error("holding drain");
   property p_empty_idle; tx_holding_empty_flag_o |-> !tx_serial_valid_o && !tx_ir_n_valid_o;
   endproperty
   a_empty_idle: assert property (p_empty_idle) else $error("empty but offering");
   property p_mode; !(tx_serial_valid_o && ir_mode_o) && !(tx_ir_n_valid_o && !ir_mode_o);
   endproperty
   a_mode: assert property (p_mode) else $error("wrong transmitter");
   property p_rx_over; !fifo_on && data_ready_flag_o && rx_v && !(rd_i && sh)
      |=> overrun_o && data_ready_flag_o; endproperty
   a_rx_over: assert property (p_rx_over) else $error("no overrun");
   property p_rx_drop; fifo_on && !rx_ready_o && rx_v && !(rd_i && sh) |=> overrun_o;
   endproperty
   a_rx_drop: assert property (p_rx_drop) else $error("drop without overrun");
   property p_rd_field; rd_i && sh |=> rdata_o[31:8] == 24'h000000; endproperty
   a_rd_field: assert property (p_rd_field) else $error("upper bits set");
   property p_dr_set; rx_v && rx_ready_o && !wr_i |=> data_ready_flag_o; endproperty
   a_dr_set: assert property (p_dr_set) else $error("data ready missing");
endmodule : uart_shadow_port_properties

// ### tb/line_partner.sv
// far-side transmitter model: takes offered bytes, promptly or every other cycle
// assumes the port holds valid and byte until the cycle it is taken
`timescale 1ns/100ps
module line_partner (
   input  wire logic clock_i,
   input  wire logic srst_i,
   input  wire logic stall_i,
   input  wire logic fast_i,
   input  wire logic serial_valid_i,
   input  wire logic ir_valid_i,
   output logic      tx_ready_o,
   output logic      got_o
);
   // ready alternates unless fast; a stall holds it low to back up the port
   always_ff @(posedge clock_i) begin
      if (srst_i || stall_i) tx_ready_o <= 1'b0;
      else tx_ready_o <= fast_i || !tx_ready_o;
   end
   assign got_o = tx_ready_o && (serial_valid_i || ir_valid_i);
endmodule : line_partner

// ### tb/uart_shadow_port_tb_top.sv
// self-checking bench for the shadow data port with a far-side transmitter model
// assumes the checker and partner files are compiled first
`timescale 1ns/100ps
`include "uart_shadow_map.svh"
module uart_shadow_port_tb_top;
   logic        clock_i, srst_i, wr_i, rd_i, rx_serial_valid_i, rx_ir_valid_i, tx_ready_i;
   logic        rx_ready_o, tx_serial_valid_o, tx_ir_n_valid_o, data_ready_flag_o, overrun_o;
   logic        tx_holding_empty_flag_o, ir_mode_o, stall, fast, got;
   logic        rd_seen = 1'b0;
   logic [31:0] addr_i, wdata_i, rdata_o;
   logic [7:0]  rx_serial_byte_i, rx_ir_byte_i, tx_byte_o, b;
   logic [31:0] exp_rd[$];
   logic [7:0]  exp_tx[$], q[$];
   int          n_errors, cmp_count, k;
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   uart_shadow_port u_dut (.clock_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .rx_serial_valid_i, .rx_serial_byte_i, .rx_ir_valid_i, .rx_ir_byte_i, .rx_ready_o,
      .tx_serial_valid_o, .tx_ir_n_valid_o, .tx_byte_o, .tx_ready_i, .data_ready_flag_o,
      .overrun_o, .tx_holding_empty_flag_o, .ir_mode_o);
   line_partner u_line (.clock_i, .srst_i, .stall_i(stall), .fast_i(fast),
      .serial_valid_i(tx_serial_valid_o), .ir_valid_i(tx_ir_n_valid_o),
      .tx_ready_o(tx_ready_i), .got_o(got));
   // =====================================================================
   // reporting
   task automatic final_report();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         n_errors++;
      end
   endtask : chk
   // =====================================================================
   // drivers: every strobe is set each cycle so none lingers into the next
   task automatic cyc(input logic w, r, s, i, input logic [31:0] a, d, input logic [7:0] v);
      wr_i <= w;
      rd_i <= r;
      addr_i <= a;
      wdata_i <= d;
      rx_serial_valid_i <= s;
      rx_ir_valid_i <= i;
      rx_serial_byte_i <= s ? v : ~rx_serial_byte_i;
      rx_ir_byte_i <= i ? v : ~rx_ir_byte_i;
      @(posedge clock_i);
   endtask : cyc
   task automatic wr(input logic [31:0] a, d);
      cyc(1'b1, 1'b0, 1'b0, 1'b0, a, d, 8'h00);
   endtask : wr
   task automatic rd(input logic [31:0] a, e);
      exp_rd.push_back(e);
      cyc(1'b0, 1'b1, 1'b0, 1'b0, a, wdata_i, 8'h00);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) cyc(1'b0, 1'b0, 1'b0, 1'b0, addr_i, wdata_i, 8'h00);
   endtask : idle
   task automatic rx(input logic i, input logic [7:0] v);
      cyc(1'b0, 1'b0, !i, i, addr_i, wdata_i, v);
      idle(1);
   endtask : rx
   // bounded wait for the holding side to drain
   task automatic wait_empty();
      for (int j = 0; j < 300; j++) begin
         idle(1);
         #1 if (tx_holding_empty_flag_o === 1'b1) return;
      end
      n_errors++;
      final_report();
   endtask : wait_empty
   // =====================================================================
   // watcher: each read answer and each taken byte meets its oldest note
   always @(posedge clock_i) begin
      if (rd_seen) chk(rdata_o, exp_rd.pop_front());
      if (got) chk({24'h0, tx_byte_o}, {24'h0, exp_tx.pop_front()});
      rd_seen <= rd_i;
   end
   // =====================================================================
   // main sequence
   initial begin
      {wr_i, rd_i, rx_serial_valid_i, rx_ir_valid_i, stall, fast} = '0;
      {addr_i, wdata_i, rx_serial_byte_i, rx_ir_byte_i} = '0;
      srst_i = 1'b1;
      void'($urandom(75));
      repeat (8) @(posedge clock_i);
      srst_i <= 1'b0;
      rd(`LINE_STATUS_ADDR, 32'h00000020);
      rd(32'h50001300, 32'h00000000);
      rd(32'h5000115d, 32'h00000000);
      // fifo off: read, then overwrite of an unread byte
      b = 8'($urandom);
      rx(1'b0, b);
      rd(`SHADOW_11_ADDR, {24'h0, b});
      rd(`LINE_STATUS_ADDR, 32'h00000020);
      rx(1'b0, ~b);
      b = 8'($urandom);
      rx(1'b0, b);
      rd(`LINE_STATUS_ADDR, 32'h00000023);
      rd(`SHADOW_12_ADDR, {24'h0, b});
      rd(`LINE_STATUS_ADDR, 32'h00000020);
      // fifo off transmit: a rewrite before draining replaces the byte
      stall <= 1'b1;
      idle(1);
      #1 chk({31'h0, tx_holding_empty_flag_o}, 32'h1);
      wr(`SHADOW_11_ADDR, 32'h00000041);
      b = 8'($urandom);
      exp_tx.push_back(b);
      wr(`SHADOW_12_ADDR, {24'h0, b});
      #1 chk({31'h0, tx_holding_empty_flag_o}, 32'h0);
      stall <= 1'b0;
      wait_empty();
      // infrared mode on both paths
      wr(`FIFO_CONTROL_ADDR, 32'h00000002);
      rd(`FIFO_CONTROL_ADDR, 32'h00000002);
      b = 8'($urandom);
      exp_tx.push_back(b);
      wr(`SHADOW_11_ADDR, {24'h0, b});
      #1 chk({29'h0, ir_mode_o, tx_ir_n_valid_o, tx_serial_valid_o}, 32'h6);
      wait_empty();
      b = 8'($urandom);
      rx(1'b1, b);
      rd(`SHADOW_12_ADDR, {24'h0, b});
      // fifo on: eight kept, the ninth dropped, read back as a burst
      wr(`FIFO_CONTROL_ADDR, 32'h00000001);
      for (k = 0; k < 9; k++) begin
         b = 8'($urandom);
         if (k < 8) q.push_back(b);
         rx(1'b0, b);
      end
      #1 chk({29'h0, rx_ready_o, overrun_o, data_ready_flag_o}, 32'h3);
      rd(`LINE_STATUS_ADDR, 32'h00000023);
      for (k = 0; k < 8; k++) rd(`SHADOW_FIRST_ADDR + 32'(4 * k), {24'h0, q.pop_front()});
      // transmit fifo: sixteen kept, the seventeenth lost, order kept
      stall <= 1'b1;
      fast <= 1'b1;
      for (k = 0; k < 17; k++) begin
         b = 8'($urandom);
         if (k < 16) exp_tx.push_back(b);
         wr(`SHADOW_FIRST_ADDR + 32'(4 * (k % 16)), {24'h0, b});
      end
      #1 chk({31'h0, tx_holding_empty_flag_o}, 32'h0);
      stall <= 1'b0;
      wait_empty();
      idle(2);
      chk(exp_tx.size(), 32'h0);
      final_report();
   end
endmodule : uart_shadow_port_tb_top
bind uart_shadow_port uart_shadow_port_properties u_props (.clock_i, .srst_i, .wr_i, .rd_i,
   .tx_ready_i, .ir_mode_o, .addr_i, .wdata_i, .rdata_o, .rx_serial_valid_i, .rx_ir_valid_i,
   .rx_ready_o, .overrun_o, .tx_serial_valid_o, .tx_ir_n_valid_o, .data_ready_flag_o,
   .tx_holding_empty_flag_o, .rx_serial_byte_i, .rx_ir_byte_i, .tx_byte_o);
